/* hdl/acc_conv_ctrl.v */
`timescale 1ns/100ps
`default_nettype none
`include "acc_defs.vh"

module acc_conv_ctrl #(
	parameter RES_W = `ACC_RES_W,
	parameter STEPS = `ACC_CONV_STEPS,
	parameter INT_DIV = `ACC_INT_DIV
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// conversion control
	input wire sample_trigger_n,
	input wire external_conversion_clock,
	input wire power_save_n,
	output reg busy_r,
	output reg sampler_hold_r,
	output reg power_down_r,
	// analog comparator result from the converter core
	input wire comparator_in,
	output reg [RES_W-1:0] dac_code_r,
	// host read port
	input wire chip_select_n,
	input wire read_n,
	output reg [RES_W-1:0] result_bus,
	output reg result_bus_oe_r
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;

	// cycles left over when the full time is split into equal steps;
	// that many early steps run one cycle longer to hit the exact time
	localparam integer EXTRA = `ACC_CONV_CYCLES - STEPS * INT_DIV;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg trig_d_r;
	reg ext_clk_d_r;
	reg use_ext_r;
	reg [7:0] div_r;
	reg [4:0] step_r;
	reg [RES_W-1:0] sar_r;
	wire [RES_W-1:0] held;
	wire start_edge;
	wire ext_edge;
	wire int_tick;
	wire tick;
	wire accept;

	// ==========================================================
	// usage notes
	// - starts during a conversion or in standby are dropped silently,
	//   so a host that needs every sample must watch busy itself
	// - the external clock source is only used for the conversion in
	//   which it was picked; each start picks afresh
	// - a free-running external clock is tolerated, but edges before
	//   the start edge are ignored and the step count starts at zero
	// - result_bus is always driven; the enable says when the pins are
	//   meant to be on the bus, and it lags select and strobe one cycle
	// - the held result changes only one cycle after busy falls, so a
	//   read started on the falling edge of busy first sees the old value

	// ==========================================================
	// divider end count for one step: the first EXTRA steps are one
	// cycle longer, the sum of all sixteen is the whole conversion time
	function [7:0] div_last;
		input [4:0] step;
		begin
			if (step < EXTRA) begin
				div_last = INT_DIV[7:0];
			end else begin
				div_last = INT_DIV[7:0] - 8'h01;
			end
		end
	endfunction

	// ==========================================================
	// edge detection
	assign start_edge = sample_trigger_n & ~trig_d_r;
	assign ext_edge = external_conversion_clock & ~ext_clk_d_r;
	assign int_tick = (div_r == div_last(step_r));
	// start taken only in idle and out of standby
	assign accept = (state_r == ST_IDLE) & start_edge & power_save_n;
	assign tick = use_ext_r ? ext_edge : int_tick;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			// high so a trigger held high through reset gives no edge
			trig_d_r <= 1'b1;
			ext_clk_d_r <= 1'b0;
		end else begin
			trig_d_r <= sample_trigger_n;
			ext_clk_d_r <= external_conversion_clock;
		end
	end

	// ==========================================================
	// state machine
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (tick && step_r == STEPS - 1) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// conversion datapath: clock pick, divider, step count, sar
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			use_ext_r <= 1'b0;
			div_r <= 8'h00;
			step_r <= 5'h00;
			sar_r <= {RES_W{1'b0}};
			dac_code_r <= {RES_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (accept) begin
				use_ext_r <= external_conversion_clock;
				div_r <= 8'h00;
				step_r <= 5'h00;
				sar_r <= {RES_W{1'b0}};
				dac_code_r <= {1'b1, {(RES_W-1){1'b0}}};
			end else if (state_r == ST_CONV) begin
				// internal oscillator stand-in, 16 ticks give 2.2 us
				// in total, with short and long steps mixed
				if (int_tick) begin
					div_r <= 8'h00;
				end else begin
					div_r <= div_r + 8'h01;
				end
				if (tick) begin
					step_r <= step_r + 5'h01;
					// bit decisions in steps 0..RES_W-1, rest settle
					if (step_r < RES_W) begin
						sar_r[RES_W-1-step_r] <= comparator_in;
						if (step_r < RES_W - 1) begin
							dac_code_r[RES_W-2-step_r] <= 1'b1;
						end
						dac_code_r[RES_W-1-step_r] <= comparator_in;
					end
				end
			end
		end
	end

	// ==========================================================
	// busy, hold and standby outputs
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			sampler_hold_r <= 1'b0;
			power_down_r <= 1'b0;
		end else begin
			power_down_r <= ~power_save_n;
			if (accept) begin
				busy_r <= 1'b1;
				sampler_hold_r <= 1'b1;
			end else if (state_nxt == ST_DONE) begin
				busy_r <= 1'b0;
				sampler_hold_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// result store, written one cycle after busy falls
	acc_result_store #(
		.W(RES_W)
	) u_store (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(state_r == ST_DONE),
		.wr_data(sar_r),
		.rd_data(held)
	);

	// ==========================================================
	// three-state read port
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			result_bus <= `ACC_RES_RST;
			result_bus_oe_r <= 1'b0;
		end else begin
			result_bus_oe_r <= ~chip_select_n & ~read_n;
			result_bus <= held;
		end
	end

endmodule // acc_conv_ctrl
`default_nettype wire

/* hdl/acc_defs.vh */
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// ==========================================================
// timing
`define ACC_CLK_PERIOD_PS 25000
`define ACC_CONV_TIME_PS 2200000
`define ACC_CONV_CYCLES (`ACC_CONV_TIME_PS / `ACC_CLK_PERIOD_PS)
`define ACC_CONV_STEPS 16
`define ACC_INT_DIV (`ACC_CONV_CYCLES / `ACC_CONV_STEPS)

// ==========================================================
// data
`define ACC_RES_W 14
`define ACC_RES_RST 14'h0000

`endif

/* hdl/acc_result_store.v */
`timescale 1ns/100ps
`default_nettype none

module acc_result_store #(
	parameter W = 14
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// write side
	input wire wr_en,
	input wire [W-1:0] wr_data,
	// read side
	output reg [W-1:0] rd_data
);

	// ==========================================================
	// held result
	// keeps last finished value until next completion
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_data <= {W{1'b0}};
		end else if (wr_en) begin
			rd_data <= wr_data;
		end
	end

endmodule // acc_result_store
`default_nettype wire

/* tb/acc_cmp_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// core comparator: keeps a trial bit while at or below the held level
module acc_cmp_model #(
	parameter logic [13:0] VAL = 14'h2A5C
) (
	// trial code in, decision out
	input wire logic [13:0] dac_code,
	output logic comparator_in
);
	// decision for the current trial code
	assign comparator_in = (dac_code <= VAL);
endmodule // acc_cmp_model
`default_nettype wire

/* tb/acc_conv_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_conv_chk (
	// watched ports
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sample_trigger_n,
	input wire logic external_conversion_clock,
	input wire logic power_save_n,
	input wire logic busy_r,
	input wire logic sampler_hold_r,
	input wire logic power_down_r,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic [13:0] dac_code_r,
	input wire logic [13:0] result_bus,
	input wire logic result_bus_oe_r
);
	// ==========
	// start edge accepted in idle while running
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_go;
		$rose(sample_trigger_n) && !busy_r && power_save_n && !power_down_r;
	endsequence
	property p_st; s_go |=> busy_r; endproperty
	property p_hb; busy_r == sampler_hold_r; endproperty
	property p_oe; result_bus_oe_r == $past(!chip_select_n && !read_n); endproperty
	property p_int;
		(s_go and !external_conversion_clock) |=>
			busy_r[*8] ##80 busy_r ##1 !busy_r;
	endproperty
	property p_pd; power_down_r == $past(!power_save_n); endproperty
	property p_sb;
		$rose(sample_trigger_n) && power_down_r && !busy_r |=> !busy_r;
	endproperty
	property p_hold; $changed(result_bus) |-> !busy_r; endproperty
	property p_dac; $rose(busy_r) |-> dac_code_r == 14'h2000; endproperty
	a_st: assert property (p_st) else $error("no busy on start");
	a_hb: assert property (p_hb) else $error("hold not with busy");
	a_oe: assert property (p_oe) else $error("bad bus enable");
	a_int: assert property (p_int) else $error("bad conv time");
	a_pd: assert property (p_pd) else $error("bad standby");
	a_sb: assert property (p_sb) else $error("start in standby");
	a_hold: assert property (p_hold) else $error("result moved");
	a_dac: assert property (p_dac) else $error("bad first trial");
	c_int: cover property (s_go and !external_conversion_clock);
	c_ext: cover property (s_go and external_conversion_clock);
	c_rd: cover property (result_bus_oe_r);
endmodule // acc_conv_chk
bind acc_conv_ctrl acc_conv_chk i_chk (.*);
`default_nettype wire

/* tb/acc_conv_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_conv_ctrl_tb;
	// ==========
	// stimulus and observed outputs
	logic sys_clk = 0, rst_n = 0, trig_n = 0, ext = 0, pwr_n = 1;
	logic cs_n = 1, rd_n = 1, busy, hold, pd, cmp, oe;
	logic [13:0] dac, bus;
	int n_mismatch = 0, checks_done = 0, cyc = 0, n;
	localparam logic [13:0] VAL = 14'h2A5C;
	acc_conv_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.sample_trigger_n(trig_n), .external_conversion_clock(ext),
		.power_save_n(pwr_n), .busy_r(busy), .sampler_hold_r(hold),
		.power_down_r(pd), .comparator_in(cmp), .dac_code_r(dac),
		.chip_select_n(cs_n), .read_n(rd_n), .result_bus(bus),
		.result_bus_oe_r(oe));
	acc_cmp_model #(.VAL(VAL)) i_cmp (.dac_code(dac), .comparator_in(cmp));
	// clock and hang guard
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 2000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	task chk(input string nm, input logic [13:0] e, g);
		checks_done++;
		if (e !== g) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// start edge after the acquisition gap
	task go(input logic e);
		repeat (12) @(posedge sys_clk);
		ext <= e;
		trig_n <= 1;
		@(posedge sys_clk);
		ext <= 0;
		trig_n <= 0;
	endtask
	task pulse(input int k);
		repeat (k) begin
			ext <= 1;
			repeat (2) @(posedge sys_clk);
			ext <= 0;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	task wait_idle;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(negedge sys_clk);
			n++;
		end
	endtask
	// read once the conversion is over
	task rd;
		@(posedge sys_clk);
		cs_n <= 0;
		rd_n <= 0;
		repeat (2) @(posedge sys_clk);
		#1 chk("oe", 1, oe);
		chk("data", VAL, bus);
		@(posedge sys_clk);
		cs_n <= 1;
		rd_n <= 1;
	endtask
	task t_int;
		go(0);
		repeat (2) @(negedge sys_clk);
		chk("hold", 1, hold);
		wait_idle;
		chk("int_len", 1, n >= 70 && n <= 88);
		rd;
		rd;
		$display("internal conversion done");
	endtask
	task t_ext;
		go(1);
		repeat (4) @(posedge sys_clk);
		pulse(15);
		#1 chk("ext_busy", 1, busy);
		pulse(1);
		wait_idle;
		chk("ext_end", 0, busy);
		rd;
		$display("external conversion done");
	endtask
	task t_sb;
		@(posedge sys_clk);
		cs_n <= 0;
		pwr_n <= 0;
		go(0);
		repeat (3) @(negedge sys_clk);
		chk("sb_busy", 0, busy);
		chk("pd", 1, pd);
		chk("cs_only", 0, oe);
		@(posedge sys_clk);
		cs_n <= 1;
		pwr_n <= 1;
		$display("standby done");
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		t_int;
		t_ext;
		t_sb;
		print_verdict;
	end
endmodule // acc_conv_ctrl_tb
`default_nettype wire
